// *** common/aas_pkg.sv ***
package aas_pkg;
	// alarm bit positions inside one channel's flag vector
	localparam int CH_TIMEOUT    = 0;
	localparam int CH_UPPER_WARN = 1;
	localparam int CH_UPPER_CRIT = 2;
	localparam int CH_FAIL       = 3;
	localparam int CH_LOWER_WARN = 4;
	localparam int CH_LOWER_CRIT = 5;
	localparam int CH_OVER_RANGE = 6;
	localparam int CH_PIN_OVLD   = 7;
	localparam int CH_POUT_OVLD  = 8;
	localparam int CH_UNDER_RNG  = 9;
	localparam int CH_FLAGS      = 10;

	// alarm bit positions inside one stream's flag vector
	localparam int ST_CRIT_OVLD  = 0;
	localparam int ST_DP_CUTOFF  = 1;
	localparam int ST_FR_CUTOFF  = 2;
	localparam int ST_COMP_FAIL  = 3;
	localparam int ST_DENS_FAIL  = 4;
	localparam int ST_DENS_DISC  = 5;
	localparam int ST_XMTR_DISC  = 6;
	localparam int ST_COMP_RANGE = 7;
	localparam int ST_FLAGS      = 8;

	// fixed limits
	localparam int PIN_MAX_HZ      = 12000;
	localparam int POUT_MAX_S      = 10;
	localparam int ITER_MAX        = 10;
	localparam int COMP_LOW_PCT    = 95;
	localparam int COMP_HIGH_PCT   = 105;
	localparam int CRIT_OVLD_NUM   = 3;  // 1.5 expressed as 3/2
	localparam int CRIT_OVLD_DEN_SH = 1;
	localparam int CLK_HZ          = 125000000;
	localparam int FLASH_HALF_MS   = 500;

	// log event kinds
	typedef enum logic [1:0] {
		AAS_EV_SET     = 2'b01,
		AAS_EV_ACK     = 2'b10,
		AAS_EV_CLEARED = 2'b11
	} aas_event_t;
endpackage

// *** design/aas_flasher.sv ***
`timescale 1ns/1ns
// divider producing the alarm indicator blink phase
module aas_flasher #(
	parameter int HALF_CYCLES = 62500000
) (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	output logic      o_phase
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        phase_r;
	logic        phase_nxt;

	// toggle the phase once per half period
	always_comb begin
		cnt_nxt = cnt_r + 32'h0000_0001;
		phase_nxt = phase_r;
		if (cnt_r >= 32'(HALF_CYCLES - 1)) begin
			cnt_nxt = 32'h0000_0000;
			phase_nxt = ~phase_r;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r <= 32'h0000_0000;
			phase_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	assign o_phase = phase_r;
endmodule

// *** design/aas_top.sv ***
`timescale 1ns/1ns
module aas_top
	import aas_pkg::*;
#(
	parameter int NCH         = 4,
	parameter int NST         = 2,
	parameter int W           = 16,
	parameter int NDO         = 4,
	parameter int FLASH_HALF  = CLK_HZ / 1000 * FLASH_HALF_MS,
	parameter int TMO_W       = 24
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_nrst,
	// channel inputs: W-bit words per channel, except 1-bit update and read-fail flags and TMO_W-bit timeouts
	input  wire logic [NCH*W-1:0]     i_ch_value,
	input  wire logic [NCH-1:0]       i_ch_update,
	input  wire logic [NCH-1:0]       i_ch_read_fail,
	input  wire logic [NCH*W-1:0]     i_upper_warn_limit,
	input  wire logic [NCH*W-1:0]     i_upper_critical_limit,
	input  wire logic [NCH*W-1:0]     i_lower_warn_limit,
	input  wire logic [NCH*W-1:0]     i_lower_critical_limit,
	input  wire logic [NCH*W-1:0]     i_scale_top,
	input  wire logic [NCH*W-1:0]     i_scale_bottom,
	input  wire logic [NCH*TMO_W-1:0] i_timeout_cycles,
	input  wire logic [NCH*W-1:0]     i_pin_freq_hz,
	input  wire logic [NCH*W-1:0]     i_pout_pending,
	input  wire logic [NCH*W-1:0]     i_pout_rate_hz,
	// stream values
	input  wire logic [NST*W-1:0]     i_uncorrected_volume_rate,
	input  wire logic [NST*W-1:0]     i_load_limit_rate,
	input  wire logic [NST*W-1:0]     i_differential_pressure,
	input  wire logic [NST*W-1:0]     i_dp_cutoff_limit,
	input  wire logic [NST*W-1:0]     i_flow_cutoff_rate,
	input  wire logic [NST*8-1:0]     i_comp_iterations,
	input  wire logic [NST*8-1:0]     i_dens_iterations,
	input  wire logic [NST*W-1:0]     i_density_a,
	input  wire logic [NST*W-1:0]     i_density_b,
	input  wire logic [NST*W-1:0]     i_density_dev_limit,
	input  wire logic [NST*W-1:0]     i_dp_a,
	input  wire logic [NST*W-1:0]     i_dp_b,
	input  wire logic [NST*W-1:0]     i_dp_dev_limit,
	input  wire logic [NST*W-1:0]     i_comp_sum_pct,
	// control and configuration
	input  wire logic                 i_ack,
	input  wire logic                 i_alarm_nc,
	input  wire logic [NDO-1:0]       i_alarm_do_sel,
	input  wire logic                 i_faulty,
	// outputs
	output logic                      o_common_alarm,
	output logic                      o_alarm_led,
	output logic                      o_alarm_contact_open,
	output logic                      o_alarm_do,
	output logic [NDO-1:0]            o_do,
	output logic                      o_run_led,
	output logic                      o_in_op_closed,
	output logic                      o_fault_closed,
	output logic                      o_log_valid,
	output aas_pkg::aas_event_t       o_log_kind,
	output logic [7:0]                o_log_index
);
	localparam int NA = NCH*CH_FLAGS + NST*ST_FLAGS;

	// absolute difference, used for both discrepancy checks
	function automatic logic [W-1:0] absdiff(input logic [W-1:0] a, input logic [W-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	logic [NA-1:0]           raw;
	logic [NA-1:0]           active_r;
	logic [NA-1:0]           active_nxt;
	logic [NA-1:0]           unacked_r;
	logic [NA-1:0]           unacked_nxt;
	logic [NCH*TMO_W-1:0]    tmo_r;
	logic [NCH*TMO_W-1:0]    tmo_nxt;
	logic [NCH-1:0]          tmo_hit;
	logic                    log_valid_nxt;
	aas_event_t              log_kind_nxt;
	logic [7:0]              log_index_nxt;
	logic                    ack_pend_r;
	logic                    ack_pend_nxt;
	logic                    phase;
	logic                    any_alarm;
	logic                    any_unacked;

	aas_flasher #(
		.HALF_CYCLES (FLASH_HALF)
	) u_flash (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.o_phase (phase)
	);

	// per-channel freshness counters, restarted by every update
	always_comb begin
		tmo_nxt = tmo_r;
		for (int c = 0; c < NCH; c++) begin
			tmo_hit[c] = tmo_r[c*TMO_W +: TMO_W] >= i_timeout_cycles[c*TMO_W +: TMO_W];
			if (i_ch_update[c])
				tmo_nxt[c*TMO_W +: TMO_W] = '0;
			else if (!tmo_hit[c])
				tmo_nxt[c*TMO_W +: TMO_W] = tmo_r[c*TMO_W +: TMO_W] + 1'b1;
		end
	end

	// alarm conditions evaluated from the present inputs
	always_comb begin
		logic [W-1:0]   v;
		logic [W+1:0]   lim;
		logic [2*W-1:0] need;
		int             b;
		v = '0;
		lim = '0;
		need = '0;
		b = 0;
		raw = '0;
		for (int c = 0; c < NCH; c++) begin
			v = i_ch_value[c*W +: W];
			b = c*CH_FLAGS;
			raw[b+CH_TIMEOUT]    = tmo_hit[c];
			raw[b+CH_UPPER_WARN] = v > i_upper_warn_limit[c*W +: W];
			raw[b+CH_UPPER_CRIT] = v > i_upper_critical_limit[c*W +: W];
			raw[b+CH_LOWER_WARN] = v < i_lower_warn_limit[c*W +: W];
			raw[b+CH_LOWER_CRIT] = v < i_lower_critical_limit[c*W +: W];
			raw[b+CH_OVER_RANGE] = v > i_scale_top[c*W +: W];
			raw[b+CH_UNDER_RNG]  = v < i_scale_bottom[c*W +: W];
			raw[b+CH_PIN_OVLD]   = 32'(i_pin_freq_hz[c*W +: W]) > PIN_MAX_HZ;
			// pending > rate * 10 s means the backlog needs more than 10 s
			need = i_pout_rate_hz[c*W +: W] * (2*W)'(POUT_MAX_S);
			raw[b+CH_POUT_OVLD]  = (2*W)'(i_pout_pending[c*W +: W]) > need;
			raw[b+CH_FAIL]       = i_ch_read_fail[c];
		end
		for (int s = 0; s < NST; s++) begin
			b = NCH*CH_FLAGS + s*ST_FLAGS;
			v = i_uncorrected_volume_rate[s*W +: W];
			// rate*2 > 3*limit avoids a fractional multiplier
			lim = (W+2)'(i_load_limit_rate[s*W +: W]) * (W+2)'(CRIT_OVLD_NUM);
			raw[b+ST_CRIT_OVLD] = ((W+2)'(v) << CRIT_OVLD_DEN_SH) > lim;
			raw[b+ST_DP_CUTOFF] = i_differential_pressure[s*W +: W]
				< i_dp_cutoff_limit[s*W +: W];
			raw[b+ST_FR_CUTOFF] = (v != '0) && (v < i_flow_cutoff_rate[s*W +: W]);
			raw[b+ST_COMP_FAIL] = 32'(i_comp_iterations[s*8 +: 8]) > ITER_MAX;
			raw[b+ST_DENS_FAIL] = 32'(i_dens_iterations[s*8 +: 8]) > ITER_MAX;
			raw[b+ST_DENS_DISC] = absdiff(i_density_a[s*W +: W], i_density_b[s*W +: W])
				> i_density_dev_limit[s*W +: W];
			raw[b+ST_XMTR_DISC] = absdiff(i_dp_a[s*W +: W], i_dp_b[s*W +: W])
				> i_dp_dev_limit[s*W +: W];
			raw[b+ST_COMP_RANGE] = (32'(i_comp_sum_pct[s*W +: W]) < COMP_LOW_PCT)
				|| (32'(i_comp_sum_pct[s*W +: W]) > COMP_HIGH_PCT);
		end
	end

	// alarm state plus one log event per cycle; lowest pending index wins,
	// so simultaneous changes are reported over successive cycles
	always_comb begin
		logic done;
		done = 1'b0;
		active_nxt = active_r;
		unacked_nxt = unacked_r;
		ack_pend_nxt = ack_pend_r | i_ack;
		log_valid_nxt = 1'b0;
		log_kind_nxt = AAS_EV_SET;
		log_index_nxt = 8'h00;
		for (int i = 0; i < NA; i++) begin
			if (!done) begin
				if (raw[i] && !active_r[i]) begin
					active_nxt[i] = 1'b1;
					unacked_nxt[i] = 1'b1;
					log_valid_nxt = 1'b1;
					log_kind_nxt = AAS_EV_SET;
					log_index_nxt = 8'(i);
					done = 1'b1;
				end else if (!raw[i] && active_r[i]) begin
					active_nxt[i] = 1'b0;
					unacked_nxt[i] = 1'b0;
					log_valid_nxt = 1'b1;
					log_kind_nxt = AAS_EV_CLEARED;
					log_index_nxt = 8'(i);
					done = 1'b1;
				end else if (ack_pend_r && unacked_r[i]) begin
					unacked_nxt[i] = 1'b0;
					log_valid_nxt = 1'b1;
					log_kind_nxt = AAS_EV_ACK;
					log_index_nxt = 8'(i);
					done = 1'b1;
				end
			end
		end
		// acknowledge stays pending until every unacked alarm has been logged
		if (!done)
			ack_pend_nxt = i_ack;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tmo_r <= '0;
			active_r <= '0;
			unacked_r <= '0;
			ack_pend_r <= 1'b0;
			o_log_valid <= 1'b0;
			o_log_kind <= AAS_EV_SET;
			o_log_index <= 8'h00;
		end else begin
			tmo_r <= tmo_nxt;
			active_r <= active_nxt;
			unacked_r <= unacked_nxt;
			ack_pend_r <= ack_pend_nxt;
			o_log_valid <= log_valid_nxt;
			o_log_kind <= log_kind_nxt;
			o_log_index <= log_index_nxt;
		end
	end

	// summary and alarm indicators from registered alarm state; run and fault outputs straight from i_faulty
	assign any_alarm = |active_r;
	assign any_unacked = |unacked_r;
	assign o_common_alarm = any_alarm;
	assign o_alarm_led = any_unacked ? phase : any_alarm;
	assign o_alarm_contact_open = any_alarm;
	// normally closed wiring inverts the driven level
	assign o_alarm_do = any_alarm ^ i_alarm_nc;
	assign o_do = i_alarm_do_sel & {NDO{o_alarm_do}};
	assign o_run_led = !i_faulty;
	assign o_in_op_closed = !i_faulty;
	assign o_fault_closed = i_faulty;
endmodule

// *** testbench/aas_top_chk.sv ***
`timescale 1ns/1ns
// watches lamps, contacts and log strobe at the top-level ports
module aas_top_chk #(
	parameter int NDO = 4
) (
	input wire logic           i_clock,
	input wire logic           i_nrst,
	input wire logic           i_alarm_nc,
	input wire logic           i_faulty,
	input wire logic [NDO-1:0] i_alarm_do_sel,
	input wire logic           o_common_alarm,
	input wire logic           o_alarm_led,
	input wire logic           o_alarm_contact_open,
	input wire logic           o_alarm_do,
	input wire logic [NDO-1:0] o_do,
	input wire logic           o_run_led,
	input wire logic           o_in_op_closed,
	input wire logic           o_fault_closed,
	input wire logic           o_log_valid
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// contact and lamp outputs follow the alarm and fault state
	contact_open_a: assert property (o_alarm_contact_open == o_common_alarm)
		else $error("alarm contact wrong");
	do_polarity_a: assert property (o_alarm_do == (o_common_alarm ^ i_alarm_nc))
		else $error("alarm output polarity wrong");
	do_route_a: assert property (o_do == ({NDO{o_alarm_do}} & i_alarm_do_sel))
		else $error("alarm output routing wrong");
	run_led_a: assert property (o_run_led == !i_faulty)
		else $error("run lamp wrong");
	in_op_side_a: assert property (o_in_op_closed == !i_faulty)
		else $error("in-operation side wrong");
	fault_side_a: assert property (o_fault_closed == i_faulty)
		else $error("fault side wrong");
	led_dark_a: assert property (!o_common_alarm |-> !o_alarm_led)
		else $error("alarm lamp lit without alarm");
	// the common alarm only moves together with a logged set or clear
	rise_logged_a: assert property ($rose(o_common_alarm) |-> o_log_valid)
		else $error("alarm raised without log event");
	fall_logged_a: assert property ($fell(o_common_alarm) |-> o_log_valid)
		else $error("alarm cleared without log event");
	cover property ($rose(o_common_alarm));
	cover property (o_common_alarm && !o_alarm_led ##1 o_alarm_led);
	cover property ($rose(i_faulty));
endmodule

bind aas_top aas_top_chk #(.NDO(NDO)) u_aas_top_chk (.*);

// *** testbench/aas_annunciator.sv ***
`timescale 1ns/1ns
// external annunciator wired to the digital alarm outputs
module aas_annunciator (
	input  wire logic [3:0] i_line,
	input  wire logic [3:0] i_sel,
	input  wire logic       i_nc,
	output logic            o_horn
);
	// decode contact sense per polarity; unwired outputs never sound it
	assign o_horn = (|i_sel) & ((|(i_line & i_sel)) ^ i_nc);
endmodule

// *** testbench/aas_top_tb.sv ***
`timescale 1ns/1ns
// integer model of one channel and one stream, compared at every step
module aas_top_tb;
	import aas_pkg::*;
	logic        i_clock, i_nrst, i_ack, i_alarm_nc, i_faulty, horn;
	logic        o_common_alarm, o_alarm_led, o_alarm_contact_open, o_alarm_do;
	logic        o_run_led, o_in_op_closed, o_fault_closed, o_log_valid;
	logic [63:0] i_ch_value, i_upper_warn_limit, i_upper_critical_limit, i_lower_warn_limit;
	logic [63:0] i_lower_critical_limit, i_scale_top, i_scale_bottom, i_pin_freq_hz;
	logic [63:0] i_pout_pending, i_pout_rate_hz;
	logic [31:0] i_uncorrected_volume_rate, i_load_limit_rate, i_differential_pressure;
	logic [31:0] i_dp_cutoff_limit, i_flow_cutoff_rate, i_density_a, i_density_b, i_dp_a;
	logic [31:0] i_density_dev_limit, i_dp_b, i_dp_dev_limit, i_comp_sum_pct;
	logic [95:0] i_timeout_cycles;
	logic [15:0] i_comp_iterations, i_dens_iterations;
	logic [3:0]  i_ch_update, i_ch_read_fail, i_alarm_do_sel, o_do;
	logic [7:0]  o_log_index;
	aas_event_t  o_log_kind;
	logic [17:0] pv, nw, un;
	logic [9:0]  q[$], eq[$];
	int          t[12], c, s, num_errors, n_compared;
	// variable, value pairs; most values sit on or just past a limit, the rest restore quiet values
	int st[82] = '{1,600, 1,601, 1,701, 1,801, 1,500, 1,399, 1,299, 1,199, 1,500, 0,1, 0,0,
		2,1, 2,0, 3,12000, 3,12001, 3,0, 4,1000, 4,1001, 4,0, 5,1500, 5,1501, 5,99, 5,0,
		5,500, 6,50, 6,49, 6,1000, 7,10, 7,11, 7,0, 8,11, 8,0, 9,20, 9,21, 9,0, 10,21, 10,0,
		11,95, 11,94, 11,106, 11,100};

	aas_top #(.FLASH_HALF(4)) u_aas_top (.*);
	aas_annunciator u_aas_annunciator (.i_line(o_do), .i_sel(i_alarm_do_sel),
		.i_nc(i_alarm_nc), .o_horn(horn));

	initial i_clock = 1'b0;
	always #4 i_clock = ~i_clock;
	// log monitor: registered pulse is read one edge after launch
	always @(posedge i_clock) if (o_log_valid === 1'b1) q.push_back({o_log_kind, o_log_index});

	// expected condition bits: 0..9 channel flags, 10..17 stream flags
	function automatic logic [17:0] mdl();
		return {t[11] < 95 || t[11] > 105, t[10] > 20, t[9] > 20, t[8] > 10, t[7] > 10,
			t[5] > 0 && t[5] < 100, t[6] < 50, 2 * t[5] > 3000, t[1] < 200, t[4] > 1000,
			t[3] > 12000, t[1] > 800, t[1] < 300, t[1] < 400, t[2] != 0, t[1] > 700,
			t[1] > 600, t[0] != 0};
	endfunction
	function automatic logic [7:0] ix(int b);
		return 8'(b < 10 ? c * 10 + b : 40 + s * 8 + b - 10);
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmpq();
		chk(32'(q.size()), 32'(eq.size()));
		foreach (eq[i]) chk(32'(q[i]), 32'(eq[i]));
		q.delete();
		eq.delete();
	endtask
	task automatic ledc(logic blink);
		int n;
		n = 0;
		repeat (12) begin
			@(posedge i_clock);
			n += (o_alarm_led === 1'b1);
		end
		chk(32'(blink ? (n > 0 && n < 12) : n), blink ? 1 : (|nw ? 12 : 0));
	endtask
	// only the chosen channel and stream leave their quiet values
	task automatic drive();
		i_ch_value = {4{16'h01f4}};
		i_ch_value[c*16+:16] = 16'(t[1]);
		i_ch_update = 4'hf;
		i_ch_update[c] = (t[0] == 0);
		i_ch_read_fail = 4'h0;
		i_ch_read_fail[c] = (t[2] != 0);
		i_pin_freq_hz = 64'h0;
		i_pin_freq_hz[c*16+:16] = 16'(t[3]);
		i_pout_pending = 64'h0;
		i_pout_pending[c*16+:16] = 16'(t[4]);
		i_uncorrected_volume_rate = {2{16'h01f4}};
		i_uncorrected_volume_rate[s*16+:16] = 16'(t[5]);
		i_differential_pressure = {2{16'h03e8}};
		i_differential_pressure[s*16+:16] = 16'(t[6]);
		i_comp_iterations = 16'h0;
		i_comp_iterations[s*8+:8] = 8'(t[7]);
		i_dens_iterations = 16'h0;
		i_dens_iterations[s*8+:8] = 8'(t[8]);
		i_density_a = {2{16'h03e8}};
		i_density_a[s*16+:16] = 16'(1000 + t[9]);
		i_dp_a = {2{16'h03e8}};
		i_dp_a[s*16+:16] = 16'(1000 + t[10]);
		i_comp_sum_pct = {2{16'h0064}};
		i_comp_sum_pct[s*16+:16] = 16'(t[11]);
		i_alarm_nc = 1'($urandom);
		i_alarm_do_sel = 4'($urandom);
		i_faulty = 1'($urandom);
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// watchdog: the steps need well under 6000 cycles
	initial begin
		#320000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h18b7));
		c = $urandom_range(3);
		s = $urandom_range(1);
		t = '{0, 500, 0, 0, 0, 500, 1000, 0, 0, 0, 0, 100};
		i_upper_warn_limit = {4{16'h0258}};
		i_upper_critical_limit = {4{16'h02bc}};
		i_lower_warn_limit = {4{16'h0190}};
		i_lower_critical_limit = {4{16'h012c}};
		i_scale_top = {4{16'h0320}};
		i_scale_bottom = {4{16'h00c8}};
		i_timeout_cycles = {4{24'h000008}};
		i_pout_rate_hz = {4{16'h0064}};
		i_load_limit_rate = {2{16'h03e8}};
		i_dp_cutoff_limit = {2{16'h0032}};
		i_flow_cutoff_rate = {2{16'h0064}};
		i_density_b = {2{16'h03e8}};
		i_dp_b = {2{16'h03e8}};
		i_density_dev_limit = {2{16'h0014}};
		i_dp_dev_limit = {2{16'h0014}};
		i_ack = 1'b0;
		un = '0;
		drive();
		i_nrst = 1'b0;
		repeat (12) @(posedge i_clock);
		#1 i_nrst = 1'b1;
		for (int i = 0; i < 82; i += 2) begin
			@(posedge i_clock);
			#1;
			pv = mdl();
			t[st[i]] = st[i+1];
			nw = mdl();
			for (int b = 0; b < 18; b++) if (pv[b] != nw[b]) eq.push_back({nw[b] ? AAS_EV_SET : AAS_EV_CLEARED, ix(b)});
			un = (un | (nw & ~pv)) & nw;
			drive();
			repeat (40) @(posedge i_clock);
			cmpq();
			chk(o_common_alarm, |nw);
			chk(horn, |nw & |i_alarm_do_sel);
			ledc(|un);
			if (|nw) begin
				#1 i_ack = 1'b1;
				@(posedge i_clock);
				#1 i_ack = 1'b0;
				for (int b = 0; b < 18; b++) if (un[b]) eq.push_back({AAS_EV_ACK, ix(b)});
				un = '0;
				repeat (30) @(posedge i_clock);
				cmpq();
				ledc(1'b0);
			end
			$display("step %0d done", i / 2);
		end
		report_and_stop();
	end
endmodule
